// >>> logic/pin_irq_pkg.sv
// constants for the external pin interrupt block
package pin_irq_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 8;
  localparam int          NUM_PINS      = 6;
  // register addresses
  localparam logic [3:0]  ADDR_PRIO_B   = 4'h0;
  localparam logic [3:0]  ADDR_FLAGS    = 4'h1;
  localparam logic [3:0]  ADDR_ENABLES  = 4'h2;
  localparam logic [3:0]  ADDR_SENSE    = 4'h3;
  localparam logic [3:0]  ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_CLR  = 4'h5;
  localparam logic [3:0]  ADDR_IRQ_EN   = 4'h6;
  // priority register fields
  localparam int          PRIO_SERIAL0  = 3;
  localparam int          PRIO_SERIAL1  = 2;
  localparam int          PRIO_CONV     = 1;
  // reset value and flag mask
  localparam logic [7:0]  RESET_VALUE   = 8'h00;
  localparam logic [7:0]  FLAG_MASK     = 8'h3F;
  // summary status register layout
  localparam int          EVT_W         = 2;
  localparam int          EVT_NEW_FLAG  = 0;
  localparam int          EVT_HW_CLEAR  = 1;
endpackage

// >>> logic/pin_irq_detect.sv
// external pin interrupt detection, flags, enables and priority register
`timescale 1ns/1ps
`default_nettype none
module pin_irq_detect
  import pin_irq_pkg::*;
(
  // clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            reset,
  input  wire logic                            hw_standby,
  // register port
  input  wire logic [pin_irq_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [pin_irq_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [pin_irq_pkg::DATA_W-1:0]  reg_rdata,
  // external request pins, active low
  input  wire logic [pin_irq_pkg::NUM_PINS-1:0] ext_request_pin_n,
  // interrupt arbitration side
  input  wire logic [pin_irq_pkg::NUM_PINS-1:0] pin_taken,
  output logic      [pin_irq_pkg::NUM_PINS-1:0] pin_request,
  output logic                                 serial0_level,
  output logic                                 serial1_level,
  output logic                                 converter_level,
  // summary interrupt
  output logic                                 irq
);
  import pin_irq_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_meta_ff;
  logic [NUM_PINS-1:0] pin_sync_ff;
  logic [NUM_PINS-1:0] pin_prev_ff;

  // idle level of the pins is high, so reset to ones avoids a false edge
  always_ff @(posedge clk_sys) begin
    if (reset || hw_standby) begin
      pin_meta_ff <= '1;
      pin_sync_ff <= '1;
      pin_prev_ff <= '1;
    end else begin
      pin_meta_ff <= ext_request_pin_n;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  wire [NUM_PINS-1:0] pin_low  = ~pin_sync_ff;
  wire [NUM_PINS-1:0] pin_fall = pin_prev_ff & ~pin_sync_ff;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]          prio_b_ff;
  logic [NUM_PINS-1:0] flags_ff;
  logic [NUM_PINS-1:0] read_one_ff;
  logic [7:0]          enables_ff;
  logic [7:0]          sense_ff;
  logic [EVT_W-1:0]    irq_stat_ff;
  logic [EVT_W-1:0]    irq_en_ff;
  logic [7:0]          rdata_ff;

  wire wr_prio   = reg_wr && (reg_addr == ADDR_PRIO_B);
  wire wr_flags  = reg_wr && (reg_addr == ADDR_FLAGS);
  wire rd_flags  = reg_rd && (reg_addr == ADDR_FLAGS);
  wire wr_enable = reg_wr && (reg_addr == ADDR_ENABLES);
  wire wr_sense  = reg_wr && (reg_addr == ADDR_SENSE);
  wire wr_iclr   = reg_wr && (reg_addr == ADDR_IRQ_CLR);
  wire wr_ien    = reg_wr && (reg_addr == ADDR_IRQ_EN);

  wire [NUM_PINS-1:0] sense_edge = sense_ff[NUM_PINS-1:0];

  // level mode sets while low; edge mode sets on a fall
  wire [NUM_PINS-1:0] flag_set =
    (~sense_edge & pin_low) | (sense_edge & pin_fall);

  // taken clears: edge mode always, level mode only with pin high
  wire [NUM_PINS-1:0] hw_clear =
    pin_taken & (sense_edge | ~pin_low);

  // a zero written where a one was read earlier clears the flag
  wire [NUM_PINS-1:0] sw_clear =
    {NUM_PINS{wr_flags}} & ~reg_wdata[NUM_PINS-1:0] & read_one_ff;

  // a new setting event wins over any clear in the same cycle
  wire [NUM_PINS-1:0] nxt_flags = (flags_ff & ~(sw_clear | hw_clear)) | flag_set;

  // read-one memory is armed by a read and dropped once the flag clears
  wire [NUM_PINS-1:0] nxt_read_one =
    rd_flags ? flags_ff : (read_one_ff & nxt_flags);

  wire [EVT_W-1:0] evt;
  assign evt[EVT_NEW_FLAG] = |(flag_set & ~flags_ff);
  assign evt[EVT_HW_CLEAR] = |(hw_clear & flags_ff);

  wire [EVT_W-1:0] nxt_irq_stat =
    (irq_stat_ff & ~({EVT_W{wr_iclr}} & reg_wdata[EVT_W-1:0])) | evt;

  always_ff @(posedge clk_sys) begin
    if (reset || hw_standby) begin
      prio_b_ff   <= RESET_VALUE;
      flags_ff    <= '0;
      read_one_ff <= '0;
      enables_ff  <= RESET_VALUE;
      sense_ff    <= RESET_VALUE;
      irq_stat_ff <= '0;
      irq_en_ff   <= '0;
    end else begin
      flags_ff    <= nxt_flags;
      read_one_ff <= nxt_read_one;
      irq_stat_ff <= nxt_irq_stat;
      if (wr_prio)   prio_b_ff  <= reg_wdata;
      if (wr_enable) enables_ff <= reg_wdata;
      if (wr_sense)  sense_ff   <= reg_wdata;
      if (wr_ien)    irq_en_ff  <= reg_wdata[EVT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      ADDR_PRIO_B:   rd_mux = prio_b_ff;
      ADDR_FLAGS:    rd_mux = {2'h0, flags_ff};
      ADDR_ENABLES:  rd_mux = enables_ff;
      ADDR_SENSE:    rd_mux = sense_ff;
      ADDR_IRQ_STAT: rd_mux = {6'h00, irq_stat_ff};
      ADDR_IRQ_EN:   rd_mux = {6'h00, irq_en_ff};
      default:       rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pin priorities live in the other priority register, outside this block
  assign reg_rdata       = rdata_ff;
  assign pin_request     = flags_ff & enables_ff[NUM_PINS-1:0];
  assign serial0_level   = prio_b_ff[PRIO_SERIAL0];
  assign serial1_level   = prio_b_ff[PRIO_SERIAL1];
  assign converter_level = prio_b_ff[PRIO_CONV];
  assign irq             = |(irq_stat_ff & irq_en_ff);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || hw_standby);

  sequence s_read_one(int i);
    rd_flags && flags_ff[i];
  endsequence

  // a zero write to a bit that was seen as one, with no set pending
  sequence s_armed_zero_write(int i);
    read_one_ff[i] && wr_flags && !reg_wdata[i] && !flag_set[i];
  endsequence

  a_read_arms_clear: assert property (
    s_read_one(1) |=> read_one_ff[1])
    else $error("reading a set flag did not arm its clear");

  a_request_gating: assert property (
    pin_request == (flags_ff & enables_ff[NUM_PINS-1:0]))
    else $error("pin request not flag and enable");

  a_level_sets_flag: assert property (
    (!sense_ff[0] && pin_low[0]) |=> flags_ff[0])
    else $error("level low did not set flag");

  a_edge_sets_flag: assert property (
    (sense_ff[1] && pin_fall[1]) |=> flags_ff[1])
    else $error("falling edge did not set flag");

  a_blind_zero_write: assert property (
    (flags_ff[1] && !read_one_ff[1] && wr_flags && !pin_taken[1]) |=> flags_ff[1])
    else $error("zero write without read cleared flag");

  a_read_then_clear: assert property (
    s_armed_zero_write(1) |=> !flags_ff[1])
    else $error("read then zero write did not clear flag");

  a_one_write_keeps: assert property (
    (flags_ff[1] && wr_flags && reg_wdata[1] && !pin_taken[1]) |=> flags_ff[1])
    else $error("writing one changed a flag");

  a_edge_taken_clr: assert property (
    (sense_ff[1] && pin_taken[1] && !pin_fall[1]) |=> !flags_ff[1])
    else $error("edge flag not cleared on take");

  a_level_taken_clr: assert property (
    (!sense_ff[0] && pin_taken[0] && !pin_low[0]) |=> !flags_ff[0])
    else $error("level flag not cleared on take");

  a_flags_high_zero: assert property (
    reg_rd && reg_addr == ADDR_FLAGS |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved flag bits read nonzero");

  a_prio_outputs: assert property (
    wr_prio |=> {serial0_level, serial1_level, converter_level}
      == {$past(reg_wdata[3]), $past(reg_wdata[2]), $past(reg_wdata[1])})
    else $error("priority outputs do not follow register");

endmodule
`default_nettype wire

// >>> verif/pin_requester.sv
// model of the external requesters that pull the active-low pins
`timescale 1ns/1ps
`default_nettype none
module pin_requester (
  // clock
  input  wire logic       clk_sys,
  // requests to present, active high
  input  wire logic [5:0] want_low,
  // request pins, pulled up when idle
  output logic      [5:0] ext_request_pin_n
);
  // pins move just after an edge, so the synchroniser sees a clean level
  always_ff @(posedge clk_sys) begin
    ext_request_pin_n <= ~want_low;
  end
endmodule
`default_nettype wire

// >>> verif/external_irq_detect_and_priority_test.sv
// self-checking bench for the external pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module external_irq_detect_and_priority_test;
  import pin_irq_pkg::*;
  // ----------
  // signals
  // ----------
  logic        clk_sys    = 1'b0;
  logic        reset      = 1'b1;
  logic        hw_standby = 1'b0;
  logic [3:0]  reg_addr   = 4'h0;
  logic [7:0]  reg_wdata  = 8'h00;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [7:0]  reg_rdata;
  logic [5:0]  want_low   = 6'h00;
  logic [5:0]  pins_n;
  logic [5:0]  pin_taken  = 6'h00;
  logic [5:0]  pin_request;
  wire  [2:0]  lv;
  logic        irq;
  int          mismatches = 0;
  int          checks     = 0;
  int          cycles     = 0;
  // rows: address, write data, read back, priority levels
  logic [22:0] rows [7] = '{{4'h0, 8'h0E, 8'h0E, 3'h7}, {4'h0, 8'h08, 8'h08, 3'h4},
    {4'h0, 8'h01, 8'h01, 3'h0}, {4'h2, 8'hC0, 8'hC0, 3'h0}, {4'h3, 8'hC0, 8'hC0, 3'h0},
    {4'h1, 8'hFF, 8'h00, 3'h0}, {4'h7, 8'hAA, 8'h00, 3'h0}};
  // ----------
  // design and partner
  // ----------
  pin_irq_detect DUT (.clk_sys(clk_sys), .reset(reset), .hw_standby(hw_standby),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_request_pin_n(pins_n), .pin_taken(pin_taken),
    .pin_request(pin_request), .serial0_level(lv[2]), .serial1_level(lv[1]),
    .converter_level(lv[0]), .irq(irq));
  pin_requester far (.clk_sys(clk_sys), .want_low(want_low), .ext_request_pin_n(pins_n));
  always #50 clk_sys = ~clk_sys;
  // a hang costs at most this many cycles before the verdict
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // pin changes need two sync stages and the flag register; six edges is safe
  task automatic pins(input logic [5:0] v);
    @(posedge clk_sys);
    want_low <= v;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic tk(input logic [5:0] v);
    @(posedge clk_sys);
    pin_taken <= v;
    @(posedge clk_sys);
    pin_taken <= 6'h00;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------
  // sequence
  // ----------
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a < 4; a++) rd(a[3:0], 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][22:19], rows[i][18:11]);
      rd(rows[i][22:19], rows[i][10:3]);
      chk({5'h00, lv}, {5'h00, rows[i][2:0]});
    end
    pins(6'h01);
    rd(4'h1, 8'h01);
    chk({2'h0, pin_request}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(4'h6, 8'h01);
    wr(4'h2, 8'hC1);
    pins(6'h01);
    chk({2'h0, pin_request}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    tk(6'h01);
    rd(4'h1, 8'h01);
    pins(6'h00);
    tk(6'h01);
    rd(4'h1, 8'h00);
    rd(4'h4, 8'h03);
    wr(4'h5, 8'h03);
    pins(6'h00);
    chk({7'h00, irq}, 8'h00);
    wr(4'h3, 8'hC2);
    pins(6'h02);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h02);
    wr(4'h1, 8'h02);
    rd(4'h1, 8'h02);
    wr(4'h1, 8'hFD);
    rd(4'h1, 8'h00);
    pins(6'h00);
    pins(6'h02);
    tk(6'h02);
    rd(4'h1, 8'h00);
    @(posedge clk_sys);
    hw_standby <= 1'b1;
    @(posedge clk_sys);
    hw_standby <= 1'b0;
    rd(4'h2, 8'h00);
    rd(4'h3, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
